// [rtl/sif_bitcnt_dec.sv]
// Purpose: Decode transfer bit counter code into bit count
// Assumes: Pure combinational, registered by the user
// Notes:   Bus format adds the acknowledge bit
`timescale 1ns/10ps
`default_nettype none
module sif_bitcnt_dec
  import sif_pkg::*;
(
  input  wire logic [2:0] i_code,
  input  wire logic       i_sync,
  output var  logic [3:0] o_bits
);
  always_comb begin
    if (i_code == BIT_CNT_IDLE) begin
      o_bits = i_sync ? SYNC_BITS_IDLE : BUS_BITS_IDLE;
    end else if (i_sync) begin
      o_bits = {1'b0, i_code};
    end else begin
      o_bits = {1'b0, i_code} + BUS_BITS_OFS;
    end
  end
endmodule
`default_nettype wire

// [rtl/sif_flag_bank.sv]
// Purpose: Bank of sticky flags with set and clear vectors
// Assumes: Set and clear are one-cycle pulses on the same clock
// Notes:   Set wins over clear so no event is lost
`timescale 1ns/10ps
`default_nettype none
module sif_flag_bank #(
  parameter int W = 6
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clr,
  output var  logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] q;
  } sif_bank_t;

  sif_bank_t st;
  sif_bank_t next_st;

  // Per-bit set-over-clear
  genvar g;
  for (g = 0; g < W; g++) begin : g_bit
    always_comb begin
      next_st.q[g] = i_set[g] | (st.q[g] & ~i_clr[g]);
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_q = st.q;
endmodule
`default_nettype wire

// [rtl/sif_irq_gate.sv]
// Purpose: Interrupt request gating for a two-wire serial controller
// Assumes: Serial engine events are one-cycle pulses on I_MCLK
// Notes:   All outputs registered; requests lag their cause by one cycle
// Register map, byte addresses, data in the low bits
//   00 enable: 7 tx-empty, 6 tx-end, 5 rx-full, 4 no-ack
//   04 status: 7 tx-empty, 6 tx-end, 5 rx-full, 4 no-ack,
//              3 arbitration lost, 2 overrun
//   08 transmit buffer, a write empties both transmit flags
//   0C receive buffer, a read frees it
//   10 bit counter code in [2:0]
//   14 event status, sticky, [4:0]
//   18 event clear, write one to clear
//   1C event enable, [4:0]
//   20 mode, bit 0 set for the clocked synchronous format
// Reserved bits read 0; unmapped addresses answer with pslverr.
// Acknowledge control bits of the enable register live elsewhere.
//
// Request lines
//   tx-empty: transmit buffer empty flag and its enable
//   tx-end:   transmit end flag and its enable
//   rx-full:  receive full flag and its enable
//   error:    synchronous overrun and either receive or no-ack enable
//   no-ack:   no-ack, arbitration lost or synchronous overrun, if enabled
//
// Status clearing
//   A status bit clears on a written 0 only after a read saw it 1.
//   Any status write forgets what earlier reads saw.
//   An event in the same cycle as a clear keeps its flag set.
//
// Timing
//   Flags follow an event by one edge, requests by two.
//   Bus answers after one wait state; pready stands one cycle.
//   An enable write reaches the requests one edge after it lands.
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sif_irq_gate
  import sif_pkg::*;
(
  input  wire logic                      I_MCLK,
  input  wire logic                      I_RESET,
  // APB slave side
  input  wire logic                      I_PSEL,
  input  wire logic                      I_PENABLE,
  input  wire logic                      I_PWRITE,
  input  wire logic [sif_pkg::ADDR_W-1:0] I_PADDR,
  input  wire logic [31:0]               I_PWDATA,
  output var  logic [31:0]               O_PRDATA,
  output var  logic                      O_PREADY,
  output var  logic                      O_PSLVERR,
  // Serial engine event pulses and receive data
  input  wire logic                      I_TX_TO_SHIFT,
  input  wire logic                      I_FRAME_CLK_END,
  input  wire logic                      I_RX_WORD_DONE,
  input  wire logic [7:0]                I_RX_DATA,
  input  wire logic                      I_NOACK_EVT,
  input  wire logic                      I_ARB_LOST_EVT,
  input  wire logic                      I_OVERRUN_EVT,
  input  wire logic                      I_XFER_DONE,
  // Towards the serial engine
  output var  logic [7:0]                O_TX_DATA,
  output var  logic [3:0]                O_XFER_BITS,
  output var  logic                      O_SYNC_MODE,
  // Interrupt requests, levels
  output var  logic                      O_TX_EMPTY_REQUEST,
  output var  logic                      O_TX_END_REQUEST,
  output var  logic                      O_RX_FULL_REQUEST,
  output var  logic                      O_ERROR_REQUEST,
  output var  logic                      O_NOACK_REQUEST,
  output var  logic                      O_IRQ
);
  import sif_pkg::*;

  typedef struct packed {
    // Enable register bits
    logic               tx_empty_irq_en;
    logic               tx_end_irq_en;
    logic               rx_full_irq_en;
    logic               noack_irq_en;
    // Data, counter and mode
    logic [7:0]         tx_buffer;
    logic [7:0]         rx_buffer;
    logic [2:0]         transfer_bit_counter;
    logic               sync_mode;
    // Event enable and status read bookkeeping
    logic [EVT_W-1:0]   evt_mask;
    logic [FLAG_W-1:0]  read_seen;
    // Bus answer
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
    // Registered request lines and decoded count
    logic               tx_empty_request;
    logic               tx_end_request;
    logic               rx_full_request;
    logic               error_request;
    logic               noack_request;
    logic               irq;
    logic [3:0]         xfer_bits;
  } sif_state_t;

  sif_state_t         st;
  sif_state_t         next_st;
  // Flag and event bank vectors, decoded count
  logic [FLAG_W-1:0]  flag_set;
  logic [FLAG_W-1:0]  flag_clr;
  logic [FLAG_W-1:0]  serial_status_flags;
  logic [EVT_W-1:0]   evt_set;
  logic [EVT_W-1:0]   evt_clr;
  logic [EVT_W-1:0]   evt_sts;
  logic [3:0]         dec_bits;
  // Bus decode
  logic               acc;
  logic               wr;
  logic               rd;
  logic               hit;
  // Register read views
  logic [7:0]         ena_byte;
  logic [7:0]         sts_byte;
  // Raw causes before enable gating
  logic               tx_empty_cause;
  logic               tx_end_cause;
  logic               rx_full_cause;
  logic               noack_cause;
  logic               overrun_cause;

  // Access completes on the edge where pready is already high
  assign acc = I_PSEL & I_PENABLE & st.pready;
  assign wr  = acc & I_PWRITE;
  assign rd  = acc & ~I_PWRITE;

  // Address decode, everything else answers with an error
  always_comb begin
    unique case (I_PADDR)
      OFS_IRQ_ENA, OFS_STATUS, OFS_TX_BUF, OFS_RX_BUF, OFS_BIT_CNT,
      OFS_EVT_STS, OFS_EVT_CLR, OFS_EVT_ENA, OFS_MODE: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Read views of the enable and status registers
  assign ena_byte = {st.tx_empty_irq_en, st.tx_end_irq_en,
                     st.rx_full_irq_en, st.noack_irq_en, 4'h0};
  assign sts_byte = {serial_status_flags, 2'h0};

  // Request causes straight from the sticky flags
  assign tx_empty_cause = serial_status_flags[FLG_TX_BUFFER_EMPTY_FLAG];
  assign tx_end_cause   = serial_status_flags[FLG_TX_END_FLAG];
  assign rx_full_cause  = serial_status_flags[FLG_RX_BUFFER_FULL_FLAG];
  // Overrun only counts as an error cause in synchronous format
  assign overrun_cause  = st.sync_mode & serial_status_flags[FLG_OVR];
  // Arbitration loss shares the no-ack request line
  assign noack_cause    = serial_status_flags[FLG_NACK] |
                          serial_status_flags[FLG_ALOST];

  // Flag set and clear; clear by writing 0 only after reading it as 1
  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    flag_set[FLG_TX_BUFFER_EMPTY_FLAG]  = I_TX_TO_SHIFT;
    flag_set[FLG_TX_END_FLAG]  = I_FRAME_CLK_END &
                          (serial_status_flags[FLG_TX_BUFFER_EMPTY_FLAG] | st.sync_mode);
    flag_set[FLG_RX_BUFFER_FULL_FLAG]  = I_RX_WORD_DONE;
    // Error flags straight from the engine
    flag_set[FLG_NACK]  = I_NOACK_EVT;
    flag_set[FLG_ALOST] = I_ARB_LOST_EVT;
    flag_set[FLG_OVR]   = I_OVERRUN_EVT;
    // Status write clears only what a read saw set
    if (wr && I_PADDR == OFS_STATUS) begin
      flag_clr = st.read_seen & ~I_PWDATA[FLAG_W+FLG_SHIFT-1:FLG_SHIFT];
    end
    // Writing the transmit buffer empties both transmit flags
    if (wr && I_PADDR == OFS_TX_BUF) begin
      flag_clr[FLG_TX_BUFFER_EMPTY_FLAG] = 1'b1;
      flag_clr[FLG_TX_END_FLAG] = 1'b1;
    end
    // Reading the receive buffer frees it
    if (rd && I_PADDR == OFS_RX_BUF) begin
      flag_clr[FLG_RX_BUFFER_FULL_FLAG] = 1'b1;
    end
  end

  // Event sticky bits, clear register is write-one-to-clear
  always_comb begin
    evt_set = '0;
    evt_set[EV_TX_END]    = flag_set[FLG_TX_END_FLAG];
    evt_set[EV_RX_FULL]   = I_RX_WORD_DONE;
    evt_set[EV_NOACK]     = I_NOACK_EVT | I_ARB_LOST_EVT;
    evt_set[EV_OVERRUN]   = I_OVERRUN_EVT;
    // Transfer done marks the event bank and also returns the bit counter to idle
    evt_set[EV_XFER_DONE] = I_XFER_DONE;
    evt_clr = '0;
    if (wr && I_PADDR == OFS_EVT_CLR) begin
      evt_clr = I_PWDATA[EVT_W-1:0];
    end
  end

  // Status flags, set wins over clear
  sif_flag_bank #(
    .W (FLAG_W)
  ) u_flags (
    .i_clk   (I_MCLK),
    .i_reset (I_RESET),
    .i_set   (flag_set),
    .i_clr   (flag_clr),
    .o_q     (serial_status_flags)
  );

  // Event bank behind the shared interrupt
  sif_flag_bank #(
    .W (EVT_W)
  ) u_events (
    .i_clk   (I_MCLK),
    .i_reset (I_RESET),
    .i_set   (evt_set),
    .i_clr   (evt_clr),
    .o_q     (evt_sts)
  );

  // Bit count decode for the serial engine
  sif_bitcnt_dec u_dec (
    .i_code (st.transfer_bit_counter),
    .i_sync (st.sync_mode),
    .o_bits (dec_bits)
  );

  // Next state: bus slave, registers and gated requests
  always_comb begin
    next_st = st;
    // One wait state so read data can come from a flop
    next_st.pready  = I_PSEL & I_PENABLE & ~st.pready;
    next_st.pslverr = I_PSEL & I_PENABLE & ~st.pready & ~hit;
    next_st.prdata  = 32'h0;
    // Read data mux, zero outside the answer cycle
    if (I_PSEL && I_PENABLE && !st.pready && !I_PWRITE) begin
      unique case (I_PADDR)
        OFS_IRQ_ENA: next_st.prdata = {24'h0, ena_byte};
        OFS_STATUS:  next_st.prdata = {24'h0, sts_byte};
        OFS_TX_BUF:  next_st.prdata = {24'h0, st.tx_buffer};
        OFS_RX_BUF:  next_st.prdata = {24'h0, st.rx_buffer};
        OFS_BIT_CNT: next_st.prdata = {29'h0, st.transfer_bit_counter};
        OFS_EVT_STS: next_st.prdata = {27'h0, evt_sts};
        OFS_EVT_ENA: next_st.prdata = {27'h0, st.evt_mask};
        OFS_MODE:    next_st.prdata = {31'h0, st.sync_mode};
        default:     next_st.prdata = 32'h0;
      endcase
    end
    // Remember flags seen as 1, forgotten once a status write lands
    if (wr && I_PADDR == OFS_STATUS) begin
      next_st.read_seen = '0;
    end
    if (rd && I_PADDR == OFS_STATUS) begin
      next_st.read_seen = serial_status_flags;
    end
    // Register writes land on the pready edge
    if (wr) begin
      unique case (I_PADDR)
        OFS_IRQ_ENA: begin
          next_st.tx_empty_irq_en = I_PWDATA[BIT_TX_EMPTY_EN];
          next_st.tx_end_irq_en   = I_PWDATA[BIT_TX_END_EN];
          next_st.rx_full_irq_en  = I_PWDATA[BIT_RX_FULL_EN];
          next_st.noack_irq_en    = I_PWDATA[BIT_NOACK_EN];
        end
        OFS_TX_BUF:  next_st.tx_buffer = I_PWDATA[7:0];
        OFS_BIT_CNT: next_st.transfer_bit_counter = I_PWDATA[2:0];
        OFS_EVT_ENA: next_st.evt_mask = I_PWDATA[EVT_W-1:0];
        OFS_MODE:    next_st.sync_mode = I_PWDATA[0];
        default: ;
      endcase
    end
    if (I_XFER_DONE) begin
      next_st.transfer_bit_counter = BIT_CNT_IDLE;
    end
    // Receive buffer loads with its flag
    if (I_RX_WORD_DONE) begin
      next_st.rx_buffer = I_RX_DATA;
    end
    next_st.tx_empty_request = tx_empty_cause & st.tx_empty_irq_en;
    next_st.tx_end_request   = tx_end_cause & st.tx_end_irq_en;
    next_st.rx_full_request  = rx_full_cause & st.rx_full_irq_en;
    next_st.error_request    = overrun_cause &
                               (st.rx_full_irq_en | st.noack_irq_en);
    next_st.noack_request    = st.noack_irq_en &
                               (noack_cause | overrun_cause);
    // Shared level interrupt from the event bank
    next_st.irq       = |(evt_sts & st.evt_mask);
    // Decoded count, one cycle behind the code
    next_st.xfer_bits = dec_bits;
  end

  // State register
  // Synchronous reset; decoded count rests at its bus idle value
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      st <= '0;
      st.xfer_bits <= BUS_BITS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops
  assign O_PRDATA           = st.prdata;
  assign O_PREADY           = st.pready;
  assign O_PSLVERR          = st.pslverr;

  // Serial engine side
  assign O_TX_DATA          = st.tx_buffer;
  assign O_XFER_BITS        = st.xfer_bits;
  assign O_SYNC_MODE        = st.sync_mode;

  // Request lines toward the host
  assign O_TX_EMPTY_REQUEST = st.tx_empty_request;
  assign O_TX_END_REQUEST   = st.tx_end_request;
  assign O_RX_FULL_REQUEST  = st.rx_full_request;
  assign O_ERROR_REQUEST    = st.error_request;
  assign O_NOACK_REQUEST    = st.noack_request;
  assign O_IRQ              = st.irq;
endmodule
`default_nettype wire

// [rtl/sif_pkg.sv]
// Purpose: Shared constants for the serial interrupt gating block
// Assumes: APB slave, 32-bit data, one word per register
// Notes:   Offsets are byte addresses
package sif_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          FLAG_W        = 6;
  localparam int          EVT_W         = 5;
  // Register byte offsets
  localparam logic [7:0]  OFS_IRQ_ENA   = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_TX_BUF    = 8'h08;
  localparam logic [7:0]  OFS_RX_BUF    = 8'h0C;
  localparam logic [7:0]  OFS_BIT_CNT   = 8'h10;
  localparam logic [7:0]  OFS_EVT_STS   = 8'h14;
  localparam logic [7:0]  OFS_EVT_CLR   = 8'h18;
  localparam logic [7:0]  OFS_EVT_ENA   = 8'h1C;
  localparam logic [7:0]  OFS_MODE      = 8'h20;
  // Enable register fields
  localparam int          BIT_TX_EMPTY_EN = 7;
  localparam int          BIT_TX_END_EN   = 6;
  localparam int          BIT_RX_FULL_EN  = 5;
  localparam int          BIT_NOACK_EN    = 4;
  // Status flag fields, bit in the flag vector; the status register bit is FLG_SHIFT higher
  localparam int          FLG_TX_BUFFER_EMPTY_FLAG      = 5;
  localparam int          FLG_TX_END_FLAG      = 4;
  localparam int          FLG_RX_BUFFER_FULL_FLAG      = 3;
  localparam int          FLG_NACK      = 2;
  localparam int          FLG_ALOST     = 1;
  localparam int          FLG_OVR       = 0;
  localparam int          FLG_SHIFT     = 2;
  // Event status fields
  localparam int          EV_TX_END     = 0;
  localparam int          EV_RX_FULL    = 1;
  localparam int          EV_NOACK      = 2;
  localparam int          EV_OVERRUN    = 3;
  localparam int          EV_XFER_DONE  = 4;
  // Reset values
  localparam logic [3:0]  RST_IRQ_ENA   = 4'h0;
  localparam logic [2:0]  RST_BIT_CNT   = 3'h0;
  localparam logic [2:0]  BIT_CNT_IDLE  = 3'h0;
  // Bit count decoding
  localparam logic [3:0]  BUS_BITS_IDLE  = 4'h9;
  localparam logic [3:0]  SYNC_BITS_IDLE = 4'h8;
  localparam logic [3:0]  BUS_BITS_OFS   = 4'h1;
endpackage

// [test/sif_intc_model.sv]
// Purpose: Host interrupt controller model at the request lines
// Assumes: Requests are levels on the system clock
// Notes:   Latches every request seen outside an ack cycle until the host acknowledges
`timescale 1ns/10ps
`default_nettype none
module sif_intc_model (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic [4:0] i_req,
  input  wire logic       i_ack,
  output var  logic [4:0] o_seen
);
  // Pending latch, so a short request outside an ack cycle is never missed by the host
  always_ff @(posedge i_clk) begin
    if (i_reset || i_ack) begin
      o_seen <= 5'h00;
    end else begin
      o_seen <= o_seen | i_req;
    end
  end
endmodule
`default_nettype wire

// [test/sif_irq_gate_props.sv]
// Purpose: Port checks for the interrupt gating block
// Assumes: One clock, synchronous active-high reset
// Notes:   Enable bits mirrored from committed APB writes
`timescale 1ns/10ps
`default_nettype none
module sif_irq_gate_props
  import sif_pkg::*;
(
  input wire logic              I_MCLK,
  input wire logic              I_RESET,
  input wire logic              I_PSEL,
  input wire logic              I_PENABLE,
  input wire logic              I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0]       I_PWDATA,
  input wire logic              O_PREADY,
  input wire logic              O_PSLVERR,
  input wire logic              I_RX_WORD_DONE,
  input wire logic              I_ARB_LOST_EVT,
  input wire logic              O_SYNC_MODE,
  input wire logic              O_TX_EMPTY_REQUEST,
  input wire logic              O_TX_END_REQUEST,
  input wire logic              O_RX_FULL_REQUEST,
  input wire logic              O_ERROR_REQUEST,
  input wire logic              O_NOACK_REQUEST
);
  logic [3:0] en;
  // Mirror counts a write only at the pready edge
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      en <= RST_IRQ_ENA;
    end else if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE
                 && I_PADDR == OFS_IRQ_ENA) begin
      en <= I_PWDATA[7:4];
    end
  end
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  chk_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
    else $error("pready held");
  chk_ready_wait: assert property (
    $rose(I_PSEL && I_PENABLE) |-> !O_PREADY ##1 O_PREADY)
    else $error("pready not after one wait");
  chk_slverr_qual: assert property (O_PSLVERR |-> O_PREADY)
    else $error("pslverr without pready");
  chk_txe_gate: assert property (
    !en[3] |=> !O_TX_EMPTY_REQUEST) else $error("tx empty ungated");
  chk_tx_end_flag_gate: assert property (
    !en[2] |=> !O_TX_END_REQUEST) else $error("tx end ungated");
  chk_rx_gate: assert property (
    !en[1] |=> !O_RX_FULL_REQUEST) else $error("rx full ungated");
  chk_rx_raise: assert property (
    I_RX_WORD_DONE && en[1] ##1 en[1] |=> O_RX_FULL_REQUEST)
    else $error("rx full request late");
  chk_nak_raise: assert property (
    I_ARB_LOST_EVT && en[0] ##1 en[0] |=> O_NOACK_REQUEST)
    else $error("noack request late");
  chk_nak_gate: assert property (
    !en[0] |=> !O_NOACK_REQUEST) else $error("noack ungated");
  chk_err_gate: assert property (
    !en[1] && !en[0] |=> !O_ERROR_REQUEST) else $error("error ungated");
  chk_err_sync: assert property (
    !O_SYNC_MODE |=> !O_ERROR_REQUEST) else $error("error in bus mode");
endmodule
bind sif_irq_gate sif_irq_gate_props sif_irq_gate_props_inst (
  .I_MCLK, .I_RESET, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR,
  .I_PWDATA, .O_PREADY, .O_PSLVERR, .I_RX_WORD_DONE, .I_ARB_LOST_EVT,
  .O_SYNC_MODE, .O_TX_EMPTY_REQUEST, .O_TX_END_REQUEST,
  .O_RX_FULL_REQUEST, .O_ERROR_REQUEST, .O_NOACK_REQUEST);
`default_nettype wire

// [test/tb.sv]
// Purpose: Self-checking bench for the interrupt gating block
// Assumes: APB answers with one wait state
// Notes:   Request vector order tx_empty, tx_end, rx_full, error, noack
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sif_pkg::*;
  logic              clk, rst, psel, pen, pwr, ack, pready, serr;
  logic              pslverr, sync, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rdv;
  logic [7:0]        rxd, txd;
  logic [6:0]        ev;
  logic [4:0]        req, seen;
  logic [3:0]        bits;
  int                n_errors, n_checks;
  sif_irq_gate sif_irq_gate_inst (.I_MCLK(clk), .I_RESET(rst),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_TX_TO_SHIFT(ev[0]), .I_FRAME_CLK_END(ev[1]),
    .I_RX_WORD_DONE(ev[2]), .I_RX_DATA(rxd), .I_NOACK_EVT(ev[3]),
    .I_ARB_LOST_EVT(ev[4]), .I_OVERRUN_EVT(ev[5]), .I_XFER_DONE(ev[6]),
    .O_TX_DATA(txd), .O_XFER_BITS(bits), .O_SYNC_MODE(sync),
    .O_TX_EMPTY_REQUEST(req[0]), .O_TX_END_REQUEST(req[1]),
    .O_RX_FULL_REQUEST(req[2]), .O_ERROR_REQUEST(req[3]),
    .O_NOACK_REQUEST(req[4]), .O_IRQ(irq));
  sif_intc_model sif_intc_model_inst (.i_clk(clk), .i_reset(rst),
    .i_req(req), .i_ack(ack), .o_seen(seen));
  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_req(input logic [4:0] e);
    chk({27'h0, req}, {27'h0, e});
  endtask
  // One transfer; two idle edges after it let gated outputs settle
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdv = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t bus answer timeout", $time);
      test_done();
    end
    repeat (2) @(posedge clk);
  endtask
  // Event pulses last one cycle; requests lag by two
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_reset();
    apb(1'b0, OFS_IRQ_ENA, 32'h0);
    chk(rdv, 32'h0); // enables clear
    chk({28'h0, bits}, 32'h9); // idle count
    apb(1'b0, 8'hFC, 32'h0);
    chk({31'h0, serr}, 32'h1);
    chk_req(5'h00);
    $display("t_reset done");
  endtask
  task automatic t_tx();
    apb(1'b1, OFS_IRQ_ENA, 32'hC0);
    pulse(0);
    chk_req(5'h01); // empty raises request
    pulse(1);
    chk_req(5'h03); // end while empty
    apb(1'b1, OFS_IRQ_ENA, 32'h80);
    chk_req(5'h01); // enable dropped
    apb(1'b1, OFS_IRQ_ENA, 32'hC0);
    chk_req(5'h03); // flag kept
    apb(1'b1, OFS_TX_BUF, 32'h5A);
    chk_req(5'h00); // buffer write clears
    chk({24'h0, txd}, 32'h5A);
    pulse(1);
    chk_req(5'h00); // no end while full
    chk({27'h0, seen}, 32'h03);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    @(posedge clk);
    chk({27'h0, seen}, 32'h00);
    $display("t_tx done");
  endtask
  task automatic t_rx();
    apb(1'b1, OFS_EVT_ENA, 32'h02);
    apb(1'b1, OFS_IRQ_ENA, 32'h20);
    rxd <= 8'hA5;
    pulse(2);
    chk_req(5'h04); // word landed
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFS_EVT_CLR, 32'h02);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, OFS_RX_BUF, 32'h0);
    chk(rdv, 32'hA5); // buffer contents
    chk_req(5'h00); // read clears flag
    apb(1'b1, OFS_EVT_ENA, 32'h00);
    pulse(2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_IRQ_ENA, 32'h00);
    chk_req(5'h00); // enable dropped
    apb(1'b0, OFS_RX_BUF, 32'h0);
    $display("t_rx done");
  endtask
  task automatic t_nak();
    apb(1'b1, OFS_IRQ_ENA, 32'h10);
    pulse(3);
    chk_req(5'h10); // no-ack
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rdv, 32'h10);
    apb(1'b1, OFS_STATUS, 32'h0);
    chk_req(5'h00); // flag cleared
    pulse(4);
    chk_req(5'h10); // arbitration lost
    apb(1'b1, OFS_IRQ_ENA, 32'h00);
    chk_req(5'h00); // enable dropped
    apb(1'b0, OFS_STATUS, 32'h0);
    apb(1'b1, OFS_STATUS, 32'h0);
    $display("t_nak done");
  endtask
  task automatic t_sync();
    apb(1'b1, OFS_MODE, 32'h1);
    chk({31'h0, sync}, 32'h1);
    apb(1'b1, OFS_IRQ_ENA, 32'h10);
    pulse(5);
    chk_req(5'h18); // overrun via no-ack enable
    apb(1'b1, OFS_IRQ_ENA, 32'h20);
    chk_req(5'h08); // overrun via receive enable
    apb(1'b1, OFS_IRQ_ENA, 32'h10);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rdv, 32'h04);
    apb(1'b1, OFS_STATUS, 32'h0);
    chk_req(5'h00); // overrun cleared
    $display("t_sync done");
  endtask
  task automatic t_rst2();
    pulse(3);
    chk_req(5'h10); // request before reset
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_req(5'h00);
    chk({31'h0, sync}, 32'h0);
    chk({28'h0, bits}, 32'h9); // idle count again
    apb(1'b0, OFS_IRQ_ENA, 32'h0);
    chk(rdv, 32'h0); // enables clear
    $display("t_rst2 done");
  endtask
  task automatic t_bits();
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, OFS_MODE, 32'(m));
      for (int c = 0; c < 8; c++) begin
        apb(1'b1, OFS_BIT_CNT, 32'(c));
        chk({28'h0, bits}, 32'((c == 0) ? 9 - m : c + 1 - m));
      end
    end
    apb(1'b1, OFS_BIT_CNT, 32'h5);
    pulse(6);
    apb(1'b0, OFS_BIT_CNT, 32'h0);
    chk(rdv, 32'h0); // counter back to idle
    chk({28'h0, bits}, 32'h8); // idle in sync format
    $display("t_bits done");
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    {psel, pen, pwr, ack} = 4'h0;
    paddr = '0;
    pwdata = 32'h0;
    ev = 7'h00;
    rxd = 8'h00;
    n_errors = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_tx();
    t_rx();
    t_nak();
    t_sync();
    t_rst2();
    t_bits();
    test_done();
  end
endmodule
`default_nettype wire
